/* File: dv/hbip_far_model.sv */
`timescale 1ns/1ps
module hbip_far_model (
  input wire logic clk_i,
  input wire logic [6:0] addr_i,
  input wire logic [15:0] wd_i,
  input wire logic [1:0] be_i,
  input wire logic wr_i,
  output logic [15:0] rd_o,
  input wire logic [1:0] pop_i,
  output logic [15:0] rxa_o,
  output logic [15:0] rxb_o,
  input wire logic [1:0] push_i,
  input wire logic [15:0] txd_i,
  output logic [15:0] tx_last_o
);
  logic [15:0] mem [128];
  logic [7:0] na = 8'h00;
  logic [7:0] nb = 8'h00;
  // Combinational answer: the port samples it one cycle after the read
  assign rd_o = mem[addr_i];
  // Heads count up per pop, so a missed or doubled pop shows in the data
  assign rxa_o = {8'hA5, na};
  assign rxb_o = {8'hB6, nb};
  initial begin
    for (int i = 0; i < 128; i++) mem[i] = 16'h0000;
    tx_last_o = 16'h0000;
  end
  always @(posedge clk_i) begin
    if (wr_i && be_i[0]) mem[addr_i][7:0] <= wd_i[7:0];
    if (wr_i && be_i[1]) mem[addr_i][15:8] <= wd_i[15:8];
    if (pop_i[0]) na <= na + 8'h01;
    if (pop_i[1]) nb <= nb + 8'h01;
    if (push_i[0]) tx_last_o <= txd_i;
  end
endmodule : hbip_far_model

/* File: dv/hbip_host_port_tb_top.sv */
`timescale 1ns/1ps
module hbip_host_port_tb_top;
  logic clk = 1'b0, rstn = 1'b0, hw_rst = 1'b0, width = 1'b1, ale = 1'b0;
  logic rd_n = 1'b1, wr_n = 1'b1, cs_n = 1'b1, be_n = 1'b1;
  logic dak_a = 1'b1, dak_b = 1'b1, iack_n = 1'b1, ch_in = 1'b1;
  logic ch_pin = 1'b0;
  logic [6:0] addr = 7'h00;
  logic [15:0] din = 16'h0000;
  logic [1:0] drv = 2'h1, casc = 2'h0, saddr = 2'h0, pup = 2'h0;
  logic [7:0] grp = 8'h00;
  logic [15:0] dout, rwd, rrd, rxa, rxb, txd, txl, cap;
  logic [1:0] doe, rbe, pop, push, pwr, cap_oe;
  logic [6:0] raddr;
  logic ack_n, ack_oe, irq, irq_oe, co, co_oe, rwr, rrdp, got;
  int err_total = 0, n_tests = 0, cycles = 0;
  localparam logic [7:0] VBASE = hbip_pkg::VEC_BASE;

  hbip_host_port u_hbip_host_port (
    .sys_clk_i(clk), .resetn_i(rstn), .hw_reset_in_i(hw_rst),
    .width_i(width), .ale_i(ale), .addr_i(addr), .data_i(din),
    .data_o(dout), .data_oe_o(doe), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .cs_n_i(cs_n), .byte_en_n_i(be_n), .dma_ack_chan_a_n_i(dak_a),
    .dma_ack_chan_b_n_i(dak_b), .irq_ack_n_i(iack_n),
    .transfer_ack_n_o(ack_n), .transfer_ack_oe_o(ack_oe),
    .irq_o(irq), .irq_oe_o(irq_oe), .chain_enable_in_i(ch_in),
    .chain_enable_out_i(ch_pin), .chain_enable_out_o(co),
    .chain_enable_out_oe_o(co_oe), .irq_drive_mode_i(drv),
    .cascade_mode_i(casc), .slave_addr_i(saddr), .irq_groups_i(grp),
    .channel_power_up_bit_i(pup), .chan_powered_o(pwr),
    .reg_addr_o(raddr), .reg_wdata_o(rwd), .reg_be_o(rbe),
    .reg_wr_o(rwr), .reg_rd_o(rrdp), .reg_rdata_i(rrd), .rx_pop_o(pop),
    .rx_data_a_i(rxa), .rx_data_b_i(rxb), .tx_push_o(push),
    .tx_data_o(txd)
  );
  hbip_far_model u_hbip_far_model (
    .clk_i(clk), .addr_i(raddr), .wd_i(rwd), .be_i(rbe), .wr_i(rwr),
    .rd_o(rrd), .pop_i(pop), .rxa_o(rxa), .rxb_o(rxb), .push_i(push),
    .txd_i(txd), .tx_last_o(txl)
  );

  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      wrap_up();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("Error t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wrap_up;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  // Holds the request until acknowledge or for at most eight cycles, then releases all of it at once
  task hold;
    got = 1'b0;
    for (int i = 0; i < 8 && !got; i++) begin
      @(negedge clk);
      if (ack_oe === 1'b1) begin
        got = 1'b1;
        cap = dout;
        cap_oe = doe;
      end
    end
    {rd_n, wr_n, iack_n, cs_n, dak_a, dak_b} = 6'h3F;
    @(negedge clk);
  endtask : hold
  task acc(input logic wr, input logic [6:0] a, input logic [15:0] d,
           input logic ben, input logic [2:0] sel);
    @(negedge clk);
    addr = a;
    din = d;
    be_n = ben;
    {cs_n, dak_a, dak_b} = sel;
    if (wr) wr_n = 1'b0;
    else rd_n = 1'b0;
    hold();
    if (sel != 3'b111) chk({15'h0000, got}, 16'h0001);
    chk({15'h0000, ack_n}, 16'h0000);
    chk({13'h0000, ack_oe, doe}, 16'h0000);
  endtask : acc
  task iack(input logic ds);
    @(negedge clk);
    iack_n = 1'b0;
    rd_n = !ds;
    hold();
  endtask : iack
  task rst;
    @(negedge clk);
    rstn = 1'b0;
    ale = 1'b0;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
  endtask : rst
  //////////////////////////////////////////////////////////////////////////
  task t_reset;
    chk({13'h0000, doe, irq_oe}, 16'h0000);
    rst();
    pup = 2'h3;
    grp = 8'h01;
    hw_rst = 1'b1;
    repeat (3) @(negedge clk);
    chk({9'h000, pwr, doe, ack_oe, irq_oe, co_oe}, 16'h0000);
    hw_rst = 1'b0;
    pup = 2'h0;
    grp = 8'h00;
    repeat (3) @(negedge clk);
    chk({14'h0000, pwr}, 16'h0000);
    pup = 2'h1;
    repeat (2) @(negedge clk);
    chk({14'h0000, pwr}, 16'h0001);
    $display("reset test done");
  endtask : t_reset
  task t_regs;
    acc(1'b1, 7'h12, 16'hBEEF, 1'b0, 3'b011);
    acc(1'b0, 7'h12, 16'h0000, 1'b0, 3'b011);
    chk(cap, 16'hBEEF);
    chk({14'h0000, cap_oe}, 16'h0003);
    acc(1'b1, 7'h13, 16'h5AC3, 1'b0, 3'b011);
    acc(1'b0, 7'h13, 16'h0000, 1'b0, 3'b011);
    chk({cap[15:8], 6'h00, cap_oe}, 16'h5A02);
    acc(1'b0, 7'h12, 16'h0000, 1'b1, 3'b011);
    chk({cap[7:0], 6'h00, cap_oe}, 16'hEF01);
    // Unselected write must leave the register alone
    acc(1'b1, 7'h12, 16'h0000, 1'b0, 3'b111);
    width = 1'b0;
    acc(1'b0, 7'h12, 16'h0000, 1'b0, 3'b011);
    chk({cap[7:0], 6'h00, cap_oe}, 16'hEF01);
    width = 1'b1;
    $display("register test done");
  endtask : t_regs
  task t_dma;
    acc(1'b0, 7'h7E, 16'h0000, 1'b0, 3'b001);
    chk(cap, 16'hA500);
    acc(1'b0, 7'h12, 16'h0000, 1'b0, 3'b110);
    chk(cap, 16'hB600);
    acc(1'b0, 7'h12, 16'h0000, 1'b0, 3'b101);
    chk(cap, 16'hA501);
    acc(1'b1, 7'h12, 16'h1234, 1'b0, 3'b001);
    chk(txl, 16'h1234);
    acc(1'b0, 7'h12, 16'h0000, 1'b0, 3'b011);
    chk(cap, 16'hBEEF);
    $display("dma test done");
  endtask : t_dma
  task t_irq_ds;
    ale = 1'b1;
    // Data-strobe mode: even address picks the upper lane
    acc(1'b0, 7'h12, 16'h0000, 1'b1, 3'b011);
    chk({cap[15:8], 6'h00, cap_oe}, 16'hBE02);
    grp = 8'h06;
    repeat (3) @(negedge clk);
    chk({15'h0000, irq}, 16'h0001);
    drv = 2'h0;
    repeat (2) @(negedge clk);
    chk({14'h0000, irq, irq_oe}, 16'h0001);
    drv = 2'h1;
    repeat (2) @(negedge clk);
    iack(1'b1);
    chk({cap[7:0] ^ VBASE, 5'h00, got, cap_oe}, 16'h0105);
    chk({15'h0000, irq}, 16'h0001);
    grp = 8'h04;
    iack(1'b1);
    chk({cap[7:0] ^ VBASE, 5'h00, got, cap_oe}, 16'h0205);
    chk({15'h0000, irq}, 16'h0000);
    grp = 8'h00;
    drv = 2'h2;
    repeat (2) @(negedge clk);
    chk({14'h0000, irq, irq_oe}, 16'h0000);
    drv = 2'h1;
    $display("data strobe interrupt test done");
  endtask : t_irq_ds
  task t_irq_rw;
    rst();
    grp = 8'h80;
    repeat (3) @(negedge clk);
    iack(1'b0);
    chk({15'h0000, irq}, 16'h0001);
    iack(1'b0);
    chk({cap[7:0] ^ VBASE, 5'h00, got, cap_oe}, 16'h0705);
    chk({15'h0000, irq}, 16'h0000);
    grp = 8'h00;
    $display("strobe interrupt test done");
  endtask : t_irq_rw
  task t_casc;
    ale = 1'b1;
    casc = 2'h1;
    saddr = 2'h1;
    grp = 8'h01;
    repeat (3) @(negedge clk);
    iack(1'b1);
    chk({15'h0000, got}, 16'h0000);
    saddr = 2'h2;
    iack(1'b1);
    chk({cap[7:0] ^ VBASE, 7'h00, got}, 16'h0001);
    grp = 8'h00;
    casc = 2'h2;
    ch_in = 1'b0;
    repeat (2) @(negedge clk);
    grp = 8'h01;
    repeat (3) @(negedge clk);
    chk({13'h0000, irq, co, co_oe}, 16'h0001);
    ch_in = 1'b1;
    repeat (3) @(negedge clk);
    chk({13'h0000, irq, co, co_oe}, 16'h0005);
    ch_in = 1'b0;
    repeat (3) @(negedge clk);
    chk({15'h0000, irq}, 16'h0000);
    iack(1'b1);
    chk({15'h0000, got}, 16'h0000);
    ch_in = 1'b1;
    repeat (3) @(negedge clk);
    iack(1'b1);
    chk({15'h0000, got}, 16'h0001);
    grp = 8'h00;
    repeat (3) @(negedge clk);
    chk({13'h0000, irq, co, co_oe}, 16'h0003);
    $display("cascade test done");
  endtask : t_casc
  task t_mux;
    rst();
    @(negedge clk);
    ale = 1'b1;
    addr = 7'h12;
    @(negedge clk);
    ale = 1'b0;
    acc(1'b0, 7'h40, 16'h0000, 1'b0, 3'b011);
    chk(cap, 16'hBEEF);
    $display("multiplexed test done");
  endtask : t_mux
  //////////////////////////////////////////////////////////////////////////
  initial begin
    @(negedge clk);
    t_reset();
    t_regs();
    t_dma();
    t_irq_ds();
    t_irq_rw();
    t_casc();
    t_mux();
    wrap_up();
  end
endmodule : hbip_host_port_tb_top

/* File: rtl/hbip_host_port.sv */
`timescale 1ns/1ps
module hbip_host_port (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic hw_reset_in_i,
  input wire logic width_i,
  input wire logic ale_i,
  input wire logic [6:0] addr_i,
  input wire logic [15:0] data_i,
  output logic [15:0] data_o,
  output logic [1:0] data_oe_o,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic cs_n_i,
  input wire logic byte_en_n_i,
  input wire logic dma_ack_chan_a_n_i,
  input wire logic dma_ack_chan_b_n_i,
  input wire logic irq_ack_n_i,
  output logic transfer_ack_n_o,
  output logic transfer_ack_oe_o,
  output logic irq_o,
  output logic irq_oe_o,
  input wire logic chain_enable_in_i,
  input wire logic chain_enable_out_i,
  output logic chain_enable_out_o,
  output logic chain_enable_out_oe_o,
  input wire logic [1:0] irq_drive_mode_i,
  input wire logic [1:0] cascade_mode_i,
  input wire logic [1:0] slave_addr_i,
  input wire logic [7:0] irq_groups_i,
  input wire logic [1:0] channel_power_up_bit_i,
  output logic [1:0] chan_powered_o,
  output logic [6:0] reg_addr_o,
  output logic [15:0] reg_wdata_o,
  output logic [1:0] reg_be_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire logic [15:0] reg_rdata_i,
  output logic [1:0] rx_pop_o,
  input wire logic [15:0] rx_data_a_i,
  input wire logic [15:0] rx_data_b_i,
  output logic [1:0] tx_push_o,
  output logic [15:0] tx_data_o
);

  typedef struct packed {
    hbip_pkg::hbip_kind_t kind;
    hbip_pkg::hbip_ackph_t ackph;
    logic cyc;
    logic done;
    logic is_rd;
    logic acc;
    logic [1:0] lanes;
    logic mux_seen;
    logic ale_prev;
    logic [6:0] addr_lat;
    logic [6:0] reg_addr;
    logic [15:0] wdata;
    logic [1:0] reg_be;
    logic reg_wr;
    logic reg_rd;
    logic [1:0] rx_pop;
    logic [1:0] tx_push;
    logic [15:0] dout;
    logic [1:0] doe;
    logic ack;
    logic [2:0] grp;
    logic [7:0] svc;
    logic irq;
    logic irq_pin;
    logic irq_oe;
    logic ceo;
    logic ceo_oe;
    logic [1:0] pwr;
  } hbip_st_t;

  hbip_st_t q;
  hbip_st_t d;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  hbip_pkg::hbip_bmode_t bmode;
  hbip_pkg::hbip_kind_t kind_now;
  logic ds_mode;
  logic strobe;
  logic rd_req;
  logic act_now;
  logic [6:0] addr_eff;
  logic [1:0] lanes_now;
  logic daisy;
  logic slave;
  logic match;
  logic [7:0] eff;
  logic top_vld;
  logic [2:0] top_idx;

  // Mux mode sticks once the latch pin has been seen to fall
  assign bmode = q.mux_seen ? hbip_pkg::BMODE_MUX :
                 (ale_i ? hbip_pkg::BMODE_DS : hbip_pkg::BMODE_RW);
  assign ds_mode = (bmode == hbip_pkg::BMODE_DS);
  assign strobe = ds_mode ? ~rd_n_i : (~rd_n_i | ~wr_n_i);
  assign rd_req = ds_mode ? (~rd_n_i & wr_n_i) : ~rd_n_i;
  assign addr_eff = (bmode == hbip_pkg::BMODE_MUX) ? q.addr_lat : addr_i;

  // Acknowledge outranks DMA, DMA outranks chip select
  always_comb begin
    if (!irq_ack_n_i) begin
      kind_now = hbip_pkg::KIND_IACK;
    end else if (!dma_ack_chan_a_n_i) begin
      kind_now = hbip_pkg::KIND_DMA_A;
    end else if (!dma_ack_chan_b_n_i) begin
      kind_now = hbip_pkg::KIND_DMA_B;
    end else if (!cs_n_i) begin
      kind_now = hbip_pkg::KIND_REG;
    end else begin
      kind_now = hbip_pkg::KIND_NONE;
    end
  end

  assign act_now = (kind_now == hbip_pkg::KIND_IACK) ?
                   (ds_mode ? ~rd_n_i : 1'b1) :
                   ((kind_now != hbip_pkg::KIND_NONE) & strobe);

  // Lane pick: strobe mode enable marks upper, data-strobe marks lower
  assign lanes_now = !width_i ? hbip_pkg::LANE_LO :
                     (ds_mode ? {~addr_eff[0], ~byte_en_n_i} :
                                {~byte_en_n_i, ~addr_eff[0]});

  assign daisy = (cascade_mode_i == hbip_pkg::CASC_DAISY);
  assign slave = (cascade_mode_i == hbip_pkg::CASC_SLAVE);
  assign match = slave ?
                 ({chain_enable_in_i, chain_enable_out_i} == slave_addr_i) :
                 (daisy ? chain_enable_in_i : 1'b1);
  assign eff = irq_groups_i & ~q.svc;

  hbip_irq_prio #(
    .N(hbip_pkg::NUM_GROUPS),
    .W(hbip_pkg::GRP_W)
  ) u_prio (
    .req_i(eff),
    .vld_o(top_vld),
    .idx_o(top_idx)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic fin;
    logic [7:0] fin_mask;
    logic inhibit;
    fin = 1'b0;
    fin_mask = '0;
    inhibit = 1'b0;
    d = q;
    d.reg_wr = 1'b0;
    d.reg_rd = 1'b0;
    d.rx_pop = '0;
    d.tx_push = '0;
    d.ale_prev = ale_i;
    if (q.ale_prev && !ale_i) begin
      d.mux_seen = 1'b1;
      d.addr_lat = addr_i;
    end
    if (!q.cyc) begin
      if (act_now) begin
        d.cyc = 1'b1;
        d.done = 1'b0;
        d.kind = kind_now;
        d.is_rd = rd_req;
        d.lanes = lanes_now;
        d.acc = 1'b0;
        case (kind_now)
          hbip_pkg::KIND_REG: begin
            d.reg_addr = addr_eff;
            d.reg_be = lanes_now;
            d.wdata = data_i;
            d.reg_rd = rd_req;
            d.reg_wr = ~rd_req;
          end
          hbip_pkg::KIND_DMA_A, hbip_pkg::KIND_DMA_B: begin
            // Address bits above zero never reach the FIFO path
            d.reg_be = lanes_now;
            d.wdata = data_i;
            if (!rd_req) begin
              d.tx_push[kind_now == hbip_pkg::KIND_DMA_B] = 1'b1;
            end
          end
          hbip_pkg::KIND_IACK: begin
            d.is_rd = 1'b1;
            if (q.ackph == hbip_pkg::ACKPH_FIRST) begin
              d.acc = 1'b1;
              d.ackph = hbip_pkg::ACKPH_SECOND;
            end else if (q.irq && match && top_vld) begin
              d.acc = 1'b1;
              d.grp = top_idx;
              d.ackph = ds_mode ? hbip_pkg::ACKPH_SECOND :
                        hbip_pkg::ACKPH_FIRST;
            end
          end
          default: begin
            d.cyc = 1'b0;
          end
        endcase
      end
    end else if (!act_now || kind_now != q.kind) begin
      d.cyc = 1'b0;
      d.done = 1'b0;
      d.doe = hbip_pkg::LANE_NONE;
      d.ack = 1'b0;
      if (q.kind == hbip_pkg::KIND_IACK &&
          q.ackph == hbip_pkg::ACKPH_SECOND) begin
        fin = 1'b1;
        fin_mask = 8'h01 << q.grp;
        d.ackph = hbip_pkg::ACKPH_IDLE;
      end
    end else if (!q.done) begin
      d.done = 1'b1;
      d.ack = (q.kind != hbip_pkg::KIND_IACK) || q.acc;
      if (q.is_rd) begin
        case (q.kind)
          hbip_pkg::KIND_REG: begin
            d.dout = reg_rdata_i;
            d.doe = q.lanes;
          end
          hbip_pkg::KIND_DMA_A: begin
            d.dout = rx_data_a_i;
            d.doe = q.lanes;
            d.rx_pop[0] = 1'b1;
          end
          hbip_pkg::KIND_DMA_B: begin
            d.dout = rx_data_b_i;
            d.doe = q.lanes;
            d.rx_pop[1] = 1'b1;
          end
          hbip_pkg::KIND_IACK: begin
            if (q.ackph == hbip_pkg::ACKPH_SECOND) begin
              d.dout = {8'h00, hbip_pkg::VEC_BASE[7:3], q.grp};
              d.doe = hbip_pkg::LANE_LO;
            end
          end
          default: begin
            d.doe = hbip_pkg::LANE_NONE;
          end
        endcase
      end
    end

    // A serviced group is not re-raised until its status clears
    d.svc = (q.svc | fin_mask) & irq_groups_i;
    inhibit = daisy && (q.ackph != hbip_pkg::ACKPH_IDLE ||
                        (q.cyc && q.kind == hbip_pkg::KIND_IACK));
    if (daisy && !chain_enable_in_i) begin
      d.irq = 1'b0;
    end else if (fin) begin
      d.irq = |(eff & ~fin_mask);
    end else if (q.irq) begin
      d.irq = |eff;
    end else begin
      d.irq = (|eff) && !inhibit;
    end
    case (irq_drive_mode_i)
      hbip_pkg::IRQ_DRV_PP_LOW: begin
        d.irq_pin = ~d.irq;
        d.irq_oe = 1'b1;
      end
      hbip_pkg::IRQ_DRV_PP_HIGH: begin
        d.irq_pin = d.irq;
        d.irq_oe = 1'b1;
      end
      default: begin
        d.irq_pin = 1'b0;
        d.irq_oe = d.irq;
      end
    endcase
    // In slave mode both chain pins are inputs carrying the address
    d.ceo = daisy && chain_enable_in_i && !d.irq;
    d.ceo_oe = daisy;
    d.pwr = channel_power_up_bit_i;
    if (hw_reset_in_i) begin
      d = '0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign data_o = q.dout;
  assign data_oe_o = q.doe;
  // Open drain: only the enable moves, the level stays low
  assign transfer_ack_n_o = 1'b0;
  assign transfer_ack_oe_o = q.ack;
  assign irq_o = q.irq_pin;
  assign irq_oe_o = q.irq_oe;
  assign chain_enable_out_o = q.ceo;
  assign chain_enable_out_oe_o = q.ceo_oe;
  assign chan_powered_o = q.pwr;
  assign reg_addr_o = q.reg_addr;
  assign reg_wdata_o = q.wdata;
  assign reg_be_o = q.reg_be;
  assign reg_wr_o = q.reg_wr;
  assign reg_rd_o = q.reg_rd;
  assign rx_pop_o = q.rx_pop;
  assign tx_push_o = q.tx_push;
  assign tx_data_o = q.wdata;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);

  AST_FLOAT_IN_RESET:
  assert property (hw_reset_in_i |=> (data_oe_o == 2'b00) && !irq_oe_o &&
                   !transfer_ack_oe_o && !chain_enable_out_oe_o)
    else $error("outputs driven during reset pin");

  AST_NARROW_LOW_LANE:
  assert property ((!width_i && !hw_reset_in_i) [*3] |-> !data_oe_o[1])
    else $error("upper lane driven in 8-bit mode");

  AST_BYTE_ONE_LANE:
  assert property (q.done && q.lanes != hbip_pkg::LANE_WORD
                   |-> data_oe_o != 2'b11)
    else $error("byte transfer drives both lanes");

  AST_REG_READ_STROBE:
  assert property (!q.cyc && act_now && kind_now == hbip_pkg::KIND_REG &&
                   rd_req && !hw_reset_in_i
                   |=> reg_rd_o && reg_addr_o == $past(addr_eff))
    else $error("register read not issued");

  AST_DMA_PUSH:
  assert property (!q.cyc && act_now && kind_now == hbip_pkg::KIND_DMA_A &&
                   !rd_req && !hw_reset_in_i
                   |=> tx_push_o == 2'b01 && tx_data_o == $past(data_i)
                   && !reg_wr_o)
    else $error("DMA write not pushed");

  AST_IACK_NO_REG:
  assert property (!irq_ack_n_i && !q.cyc |=> !reg_wr_o && !reg_rd_o)
    else $error("register touched in acknowledge cycle");

  AST_ACK_RELEASE:
  assert property (q.cyc && !act_now && !hw_reset_in_i
                   |=> !transfer_ack_oe_o && data_oe_o == 2'b00)
    else $error("acknowledge held after strobe ended");

  AST_DAISY_GATE:
  assert property (daisy && !chain_enable_in_i |=> !q.irq)
    else $error("request raised with chain disabled");

  AST_CHAIN_OUT:
  assert property (daisy && (!chain_enable_in_i || d.irq) && !hw_reset_in_i
                   |=> !chain_enable_out_o)
    else $error("chain output not pulled low");

  AST_VECTOR_VALUE:
  assert property (q.kind == hbip_pkg::KIND_IACK && data_oe_o[0]
                   |-> data_o[7:0] == {hbip_pkg::VEC_BASE[7:3], q.grp})
    else $error("wrong interrupt vector");

  COV_REG_WRITE: cover property (reg_wr_o);
  COV_DMA_READ: cover property (rx_pop_o != 2'b00);
  COV_VECTOR_OUT: cover property (q.kind == hbip_pkg::KIND_IACK &&
                                  data_oe_o[0]);
  COV_MUX_MODE: cover property (q.mux_seen && reg_rd_o);

endmodule : hbip_host_port

/* File: rtl/hbip_irq_prio.sv */
`timescale 1ns/1ps
module hbip_irq_prio #(
  parameter int N = 8,
  parameter int W = 3
) (
  input wire logic [N-1:0] req_i,
  output logic vld_o,
  output logic [W-1:0] idx_o
);

  // Group 0 wins; scanning downward lets the lowest index overwrite
  always_comb begin
    vld_o = |req_i;
    idx_o = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        idx_o = W'(i);
      end
    end
  end

endmodule : hbip_irq_prio

/* File: rtl/hbip_pkg.sv */
// What this block does
// - Narrow bus uses only the low byte
// - Byte transfer drives one lane, other floats
// - Latch pin level or toggling selects bus protocol
// - Address captured on latch fall; host wires
// - Register read drives selected register onto bus
// - Register write loads selected register from bus
// - DMA read pops receive FIFO, low address
// - DMA write pushes transmit FIFO, address ignored
// - Chip select gates registers, ignored otherwise
// - Reset pin floats outputs; channels stay down
// - Byte enable meaning depends on bus mode
// - Transfer acknowledge held until strobe ends
// - Interrupt pin combines sources; configurable drive
// - Request drops when clear or chain low
// - Daisy chain requests only with chain high
// - Acknowledge returns vector of top group
// - Data-strobe mode drops request after one cycle
// - Strobe mode drops request after second cycle
// - Slave mode accepts matching chain address only
// - Daisy mode accepts only with chain high
// - Chain output follows input and own request
package hbip_pkg;

  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam int NUM_GROUPS = 8;
  localparam int GRP_W = 3;

  localparam logic [1:0] LANE_NONE = 2'h0;
  localparam logic [1:0] LANE_LO = 2'h1;
  localparam logic [1:0] LANE_HI = 2'h2;
  localparam logic [1:0] LANE_WORD = 2'h3;

  localparam logic [1:0] CASC_NONE = 2'h0;
  localparam logic [1:0] CASC_SLAVE = 2'h1;
  localparam logic [1:0] CASC_DAISY = 2'h2;

  localparam logic [1:0] IRQ_DRV_PP_LOW = 2'h0;
  localparam logic [1:0] IRQ_DRV_PP_HIGH = 2'h1;
  localparam logic [1:0] IRQ_DRV_OPEN = 2'h2;

  // Upper five vector bits are fixed; the low three carry the group
  localparam logic [7:0] VEC_BASE = 8'hA0;

  typedef enum logic [1:0] {
    BMODE_RW,
    BMODE_DS,
    BMODE_MUX
  } hbip_bmode_t;

  typedef enum logic [2:0] {
    KIND_NONE,
    KIND_REG,
    KIND_DMA_A,
    KIND_DMA_B,
    KIND_IACK
  } hbip_kind_t;

  typedef enum logic [1:0] {
    ACKPH_IDLE,
    ACKPH_FIRST,
    ACKPH_SECOND
  } hbip_ackph_t;

endpackage : hbip_pkg
